// ### src/tuoh_handler.v
// Opcode handler: decodes 8-bit opcodes from the high byte of 16-bit words, moves data words, keeps state.
// Assumes the host sees busy as the wait status; converter pins are asynchronous and synchronized here.
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
`include "tuoh_map.vh"

module tuoh_handler #(
  parameter [15:0] ID_CODE   = 16'h1234, // Arbitrary identification value
  parameter [7:0]  FW_REV    = 8'h10,    // Arbitrary firmware revision
  parameter        SMALL_VAR = 0         // 1 selects the 16-channel variant
) (
  input  wire         clk_sys_in,
  input  wire         rstn_in,
  input  wire         wr_in,
  input  wire         rd_in,
  input  wire [15:0]  wdata_in,
  output reg  [15:0]  rdata_out,
  output wire         busy_out,
  input  wire [43:0]  conv_err_in,
  input  wire [3:0]   conv_lock_in,
  input  wire [247:0] conv_stat_in,
  output reg          loop_rst_out,
  output reg          save_cal_out,
  output reg  [3:0]   load_out,
  output reg          load_def_out,
  output reg          parity_out,
  output reg  [10:0]  coarse_out,
  output reg  [4:0]   fine_out
);

  // Handler states, one-hot
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WR   = 3'b010;
  localparam [2:0] ST_RD   = 3'b100;

  reg [2:0]  state;
  reg [7:0]  op;
  reg [7:0]  arg;
  reg [1:0]  cnt;
  reg [1:0]  need;
  reg [7:0]  ch_adj [0:31];
  reg [11:0] cal [0:3];
  reg [15:0] img [0:40];

  wire [5:0] n_ch   = SMALL_VAR ? 6'h10 : `TUOH_NUM_CH;
  wire [2:0] n_conv = SMALL_VAR ? 3'h2 : `TUOH_NUM_CONV;
  wire [7:0] cmd    = wdata_in[15:8];
  wire [1:0] cv     = arg[1:0];

  // Wait status while data words are outstanding
  assign busy_out = (state != ST_IDLE);

  // Converter lines come from another domain: error, lock and status bits
  localparam PIN_W = 296;
  wire [PIN_W-1:0] pin_raw = {conv_stat_in, conv_lock_in, conv_err_in};
  reg  [PIN_W-1:0] pin_s1;
  reg  [PIN_W-1:0] pin_s2;
  reg  [PIN_W-1:0] pin_s3;
  reg  [PIN_W-1:0] pin_q;

  // Three-stage capture; only the second stage reads the first
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_s1 <= {PIN_W{1'b0}};
      pin_s2 <= {PIN_W{1'b0}};
      pin_s3 <= {PIN_W{1'b0}};
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // A bit is taken once the second and third stages agree
  genvar p;
  generate
    for (p = 0; p < PIN_W; p = p + 1) begin : g_pin
      always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
          pin_q[p] <= 1'b0;
        end else if (pin_s2[p] == pin_s3[p]) begin
          pin_q[p] <= pin_s3[p];
        end
      end
    end
  endgenerate

  // Settled converter words, same layout as the pins
  wire [43:0]  err_q  = pin_q[43:0];
  wire [3:0]   lock_q = pin_q[47:44];
  wire [247:0] stat_q = pin_q[295:48];

  // Image parity over the 646 significant bits
  reg     par;
  integer k;
  always @* begin
    par = 1'b0;
    for (k = 0; k < 40; k = k + 1)
      par = par ^ (^img[k]);
    par = par ^ (^img[40][5:0]);
  end

  // Read word selection for the active opcode
  reg [15:0] rword;
  always @* begin
    rword = 16'h0000;
    case (op)
      `TUOH_OP_RD_GOFS:  rword = (cnt == 2'd0) ? {5'h00, coarse_out} : {11'h000, fine_out};
      `TUOH_OP_RD_CHADJ: rword = {8'h00, ch_adj[arg[4:0]]};
      `TUOH_OP_RD_CAL:   rword = {4'h0, cal[cv]};
      `TUOH_OP_RD_ID:    rword = ID_CODE;
      `TUOH_OP_RD_FW:    rword = {8'h00, FW_REV};
      `TUOH_OP_RD_IMG:   rword = img[arg[5:0]];
      `TUOH_OP_RD_ERR:   rword = {5'h00, err_q[cv*11 +: 11]};
      `TUOH_OP_RD_LOCK:  rword = {15'h0000, lock_q[cv]};
      `TUOH_OP_RD_STAT:  rword = stat_q[cv*62 + cnt*16 +: 16];
      default:           rword = 16'h0000;
    endcase
  end

  // Image storage, cleared at reset
  genvar g;
  generate
    for (g = 0; g < 41; g = g + 1) begin : g_img
      always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
          img[g] <= 16'h0000;
        end else if (state == ST_WR && wr_in && op == `TUOH_OP_WR_IMG && arg == g) begin
          img[g] <= wdata_in; // Stored only, converters untouched
        end
      end
    end
    for (g = 0; g < 32; g = g + 1) begin : g_ch
      always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
          ch_adj[g] <= `TUOH_CHADJ_RST;
        end else if (state == ST_WR && wr_in && op == `TUOH_OP_SET_CHADJ && arg == g) begin
          ch_adj[g] <= wdata_in[7:0]; // Upper byte dropped
        end
      end
    end
    for (g = 0; g < 4; g = g + 1) begin : g_cal
      always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
          cal[g] <= `TUOH_CAL_RST;
        end else if (state == ST_WR && wr_in && op == `TUOH_OP_SET_CAL && arg == g) begin
          cal[g] <= wdata_in[11:0];
        end
      end
    end
  endgenerate

  // Opcode decode and data word sequencing
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state        <= ST_IDLE;
      op           <= 8'h00;
      arg          <= 8'h00;
      cnt          <= 2'd0;
      need         <= 2'd0;
      rdata_out    <= 16'h0000;
      loop_rst_out <= 1'b0;
      save_cal_out <= 1'b0;
      load_out     <= 4'h0;
      load_def_out <= 1'b0;
      parity_out   <= 1'b0;
      coarse_out   <= `TUOH_COARSE_RST;
      fine_out     <= `TUOH_FINE_RST;
    end else begin
      loop_rst_out <= 1'b0;
      save_cal_out <= 1'b0;
      load_out     <= 4'h0;
      load_def_out <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (wr_in) begin
            op  <= cmd;
            arg <= wdata_in[7:0]; // Low byte kept, unused for don't-care codes
            cnt <= 2'd0;
            case (cmd)
              `TUOH_OP_SET_GOFS: begin
                state <= ST_WR;
                need  <= 2'd1;
              end
              `TUOH_OP_RD_GOFS: begin
                state <= ST_RD;
                need  <= 2'd1;
              end
              `TUOH_OP_SET_CHADJ, `TUOH_OP_RD_CHADJ: begin
                // Out-of-range channel: ignored entirely
                if ({2'b00, wdata_in[5:0]} < {2'b00, n_ch} && wdata_in[7:6] == 2'b00) begin
                  state <= (cmd == `TUOH_OP_SET_CHADJ) ? ST_WR : ST_RD;
                  need  <= 2'd0;
                end
              end
              `TUOH_OP_SET_CAL, `TUOH_OP_RD_CAL, `TUOH_OP_RD_ID, `TUOH_OP_RD_ERR,
              `TUOH_OP_RD_LOCK, `TUOH_OP_RD_STAT: begin
                if (wdata_in[7:2] == 6'h00 && {1'b0, wdata_in[1:0]} < n_conv) begin
                  state <= (cmd == `TUOH_OP_SET_CAL) ? ST_WR : ST_RD;
                  need  <= (cmd == `TUOH_OP_RD_STAT) ? 2'd3 : 2'd0;
                end
              end
              `TUOH_OP_RD_FW: begin
                state <= ST_RD;
                need  <= 2'd0;
              end
              `TUOH_OP_WR_IMG, `TUOH_OP_RD_IMG: begin
                if (wdata_in[7:0] <= {2'b00, `TUOH_IMG_LAST}) begin
                  state <= (cmd == `TUOH_OP_WR_IMG) ? ST_WR : ST_RD;
                  need  <= 2'd0;
                end
              end
              `TUOH_OP_SAVE_CAL: save_cal_out <= 1'b1;
              `TUOH_OP_RST_LOOPS: loop_rst_out <= 1'b1;
              `TUOH_OP_LOAD_IMG: begin
                load_out   <= 4'hf;  // All converters
                parity_out <= par;
              end
              `TUOH_OP_LOAD_DEF: load_def_out <= 1'b1;
              `TUOH_OP_LOAD_ONE: begin
                if (wdata_in[7:2] == 6'h00 && {1'b0, wdata_in[1:0]} < n_conv) begin
                  load_out   <= 4'h1 << wdata_in[1:0]; // Only converter n
                  parity_out <= par;
                end
              end
              default: state <= ST_IDLE;
            endcase
          end
        end
        ST_WR: begin
          if (wr_in) begin
            if (op == `TUOH_OP_SET_GOFS) begin
              if (cnt == 2'd0)
                coarse_out <= wdata_in[10:0];
              else
                fine_out <= wdata_in[4:0];
            end
            cnt <= cnt + 2'd1;
            if (cnt == need)
              state <= ST_IDLE; // Last word moved
          end
        end
        ST_RD: begin
          if (rd_in) begin
            rdata_out <= rword;
            cnt       <= cnt + 2'd1;
            if (cnt == need)
              state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule

// ### src/tuoh_map.vh
// Constants for the timing unit opcode handler: opcodes, sizes, field widths.
// Assumes a 20 MHz system clock and a single 16-bit command/data port.
//
// Notes on behaviour
// - Set global offset takes two writes: 11-bit coarse, then 5-bit fine.
// - Read global offset returns coarse first, then fine.
// - Handler waits until every data word is moved; no new opcode meanwhile.
// - Set channel adjust: index in low byte, one write, keep bits 7..0.
// - Read channel adjust returns one word, offset in bits 7..0.
// - Set calibration of converter n: one write, twelve low bits kept.
// - Read calibration of converter n: one word carrying twelve-bit value.
// - Save calibration stores converter calibration into nonvolatile memory.
// - Read identity of converter n returns one word, revision-dependent.
// - Firmware revision read: low byte holds major and minor digits.
// - Reset loops pulses the converters' PLL and DLL reset.
// - Image of 646 bits plus parity held as 16-bit words, bit k at word k/16.
// - Parity bit computed and inserted when converters are programmed.
// - Write image word nn stores only; converters unchanged until load.
// - Read image word nn returns the stored word.
// - Load image shifts the stored image into all converters.
// - Reload default programs all converters with the default image.
// - Read errors of converter n: eleven low bits flag errors.
// - Read lock of converter n: bit 0 is DLL lock.
// - Read status of converter n: four words carry 62-bit status.
// - Load single converter n with the stored image only.
`ifndef TUOH_MAP_VH
`define TUOH_MAP_VH

`define TUOH_OP_SET_GOFS   8'h50
`define TUOH_OP_RD_GOFS    8'h51
`define TUOH_OP_SET_CHADJ  8'h52
`define TUOH_OP_RD_CHADJ   8'h53
`define TUOH_OP_SET_CAL    8'h54
`define TUOH_OP_RD_CAL     8'h55
`define TUOH_OP_SAVE_CAL   8'h56
`define TUOH_OP_RD_ID      8'h60
`define TUOH_OP_RD_FW      8'h61
`define TUOH_OP_RST_LOOPS  8'h62
`define TUOH_OP_WR_IMG     8'h70
`define TUOH_OP_RD_IMG     8'h71
`define TUOH_OP_LOAD_IMG   8'h72
`define TUOH_OP_LOAD_DEF   8'h73
`define TUOH_OP_RD_ERR     8'h74
`define TUOH_OP_RD_LOCK    8'h75
`define TUOH_OP_RD_STAT    8'h76
`define TUOH_OP_LOAD_ONE   8'h77

`define TUOH_NUM_CH        6'h20
`define TUOH_NUM_CONV      3'h4
`define TUOH_IMG_WORDS     6'h29
`define TUOH_IMG_LAST      6'h28
`define TUOH_PARITY_BIT    4'h6
`define TUOH_COARSE_W      11
`define TUOH_FINE_W        5
`define TUOH_CAL_W         12
`define TUOH_ERR_W         11
`define TUOH_COARSE_RST    11'h000
`define TUOH_FINE_RST      5'h00
`define TUOH_CHADJ_RST     8'h00
`define TUOH_CAL_RST       12'h000

`endif

// ### dv/tuoh_checker_properties.sv
// Checker: port relations of the opcode handler.
// Assumes a bind onto tuoh_handler and one clock domain.
`timescale 1ns/1ps
module tuoh_checker (
  input wire        clk_sys_in,
  input wire        rstn_in,
  input wire        wr_in,
  input wire        rd_in,
  input wire [15:0] wdata_in,
  input wire        busy_out,
  input wire        loop_rst_out,
  input wire        save_cal_out,
  input wire [3:0]  load_out,
  input wire        load_def_out,
  input wire [10:0] coarse_out,
  input wire [4:0]  fine_out
);
  // Opcode taken while idle
  wire [7:0] op   = wdata_in[15:8];
  wire       take = wr_in && !busy_out;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  a_loop_rst_pulse: assert property (take && op == 8'h62 |=> loop_rst_out ##1 !loop_rst_out)
    else $error("loop reset pulse wrong");
  a_save_cal_pulse: assert property (take && op == 8'h56 |=> save_cal_out && !busy_out)
    else $error("save pulse wrong");
  a_load_all_conv: assert property (take && op == 8'h72 |=> load_out == 4'hf)
    else $error("load all wrong");
  a_load_def_only: assert property (take && op == 8'h73 |=> load_def_out && load_out == 4'h0)
    else $error("default load wrong");
  a_load_one_conv: assert property (take && op == 8'h77 && wdata_in[7:2] == 6'h00
    |=> $onehot(load_out))
    else $error("single load wrong");
  a_wait_holds: assert property (busy_out && !wr_in && !rd_in |=> busy_out)
    else $error("wait state left early");
  a_gofs_two_words: assert property (take && op == 8'h50 |=> busy_out ##1 busy_out)
    else $error("offset wait too short");
  a_offs_idle_hold: assert property (!busy_out |=> $stable(coarse_out) && $stable(fine_out))
    else $error("offsets moved while idle");
  a_bad_chan_drop: assert property (take && op == 8'h52 && wdata_in[7:5] != 3'h0
    |=> !busy_out)
    else $error("bad channel accepted");
endmodule

// ### dv/tuoh_conv_model.sv
// Converter side: fixed error, lock and status words.
// Assumes the handler only samples these lines.
`timescale 1ns/1ps
module tuoh_conv_model (
  output wire [43:0]  conv_err_out,
  output wire [3:0]   conv_lock_out,
  output wire [247:0] conv_stat_out
);
  // Distinct error and status patterns per converter; lock bits alternate 0,1,0,1
  assign conv_err_out  = 44'habcdef01234;
  assign conv_lock_out = 4'ha;
  assign conv_stat_out = {62'h1bad_cafe_1234_5678, 62'h2c3d_4e5f_6071_8293,
                          62'h3f0e_d1c2_b3a4_9586, 62'h0123_4567_89ab_cdef};
endmodule

// ### dv/timing_unit_opcode_handler_tb.sv
// Bench: host tasks and one task per scenario.
// Assumes 20 MHz clock and the converter model on the status inputs.
`timescale 1ns/1ps
module timing_unit_opcode_handler_tb;
  reg          clk_sys_in = 1'b0;
  reg          rstn_in = 1'b0;
  reg          wr_in = 1'b0;
  reg          rd_in = 1'b0;
  reg  [15:0]  wdata_in = 16'h0000;
  wire [15:0]  rdata_out;
  wire         busy_out, loop_rst_out, save_cal_out, load_def_out, parity_out;
  wire [3:0]   load_out, conv_lock_in;
  wire [10:0]  coarse_out;
  wire [4:0]   fine_out;
  wire [43:0]  conv_err_in;
  wire [247:0] conv_stat_in;
  integer      errors = 0;
  integer      num_checks = 0;
  integer      i, j;
  always #25 clk_sys_in = ~clk_sys_in;
  // Identity and revision values are arbitrary
  tuoh_handler #(.ID_CODE(16'h2c4e), .FW_REV(8'h21)) dut (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .wr_in(wr_in), .rd_in(rd_in),
    .wdata_in(wdata_in), .rdata_out(rdata_out), .busy_out(busy_out),
    .conv_err_in(conv_err_in), .conv_lock_in(conv_lock_in), .conv_stat_in(conv_stat_in),
    .loop_rst_out(loop_rst_out), .save_cal_out(save_cal_out), .load_out(load_out),
    .load_def_out(load_def_out), .parity_out(parity_out), .coarse_out(coarse_out),
    .fine_out(fine_out));
  tuoh_conv_model conv (.conv_err_out(conv_err_in), .conv_lock_out(conv_lock_in),
                        .conv_stat_out(conv_stat_in));
  task summarize;
    begin
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [15:0] d);
    begin
      @(posedge clk_sys_in);
      wr_in <= 1'b1;
      wdata_in <= d;
      @(posedge clk_sys_in);
      wr_in <= 1'b0;
      #1;
    end
  endtask
  task rd(input [15:0] m, input [15:0] exp);
    begin
      @(posedge clk_sys_in);
      rd_in <= 1'b1;
      @(posedge clk_sys_in);
      rd_in <= 1'b0;
      #1;
      chk(rdata_out & m, exp & m);
    end
  endtask
  task s_gofs;
    begin
      wr(16'h50a5);
      rd(16'h0000, 16'h0000);
      chk({15'h0, busy_out}, 16'h0001);
      wr(16'hfabc);
      wr(16'hffe3);
      chk({5'h0, coarse_out}, 16'h02bc);
      chk({11'h0, fine_out}, 16'h0003);
      wr(16'h5100);
      rd(16'h07ff, 16'h02bc);
      rd(16'h001f, 16'h0003);
      chk({15'h0, busy_out}, 16'h0000);
    end
  endtask
  task s_adj;
    begin
      for (i = 0; i < 32; i = i + 31) begin
        wr({8'h52, i[7:0]});
        wr(16'h12ab ^ i[15:0]);
        wr({8'h53, i[7:0]});
        rd(16'h00ff, 16'h00ab ^ i[15:0]);
      end
      wr(16'h5220);
      chk({15'h0, busy_out}, 16'h0000);
      for (i = 0; i < 4; i = i + 1) begin
        wr(16'h5400 | i[15:0]);
        wr(16'hf120 | i[15:0]);
      end
      wr(16'h5404);
      chk({15'h0, busy_out}, 16'h0000);
      for (i = 0; i < 4; i = i + 1) begin
        wr(16'h5500 | i[15:0]);
        rd(16'h0fff, 16'h0120 | i[15:0]);
      end
    end
  endtask
  task s_img;
    begin
      wr(16'h7028);
      wr(16'hbeef);
      chk({12'h0, load_out}, 16'h0000);
      wr(16'h7128);
      rd(16'hffff, 16'hbeef);
      wr(16'h7029);
      chk({15'h0, busy_out}, 16'h0000);
      wr(16'h72ff);
      chk({12'h0, load_out}, 16'h000f);
      @(posedge clk_sys_in);
      #1;
      chk({15'h0, parity_out}, 16'h0001);
      wr(16'h7702);
      chk({12'h0, load_out}, 16'h0004);
      wr(16'h73c3);
      chk({15'h0, load_def_out}, 16'h0001);
    end
  endtask
  task s_misc;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        wr(16'h6000 | i[15:0]);
        rd(16'hffff, 16'h2c4e);
        wr(16'h7400 | i[15:0]);
        rd(16'h07ff, {5'h0, conv_err_in[i*11 +: 11]});
        wr(16'h7500 | i[15:0]);
        rd(16'h0001, {15'h0, conv_lock_in[i]});
        wr(16'h7600 | i[15:0]);
        for (j = 0; j < 4; j = j + 1)
          rd(j == 3 ? 16'h3fff : 16'hffff, conv_stat_in[i*62+j*16 +: 16]);
      end
      wr(16'h6177);
      rd(16'h00ff, 16'h0021);
      wr(16'h62ff);
      chk({15'h0, loop_rst_out}, 16'h0001);
      wr(16'h5611);
      chk({15'h0, save_cal_out}, 16'h0001);
    end
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    errors = errors + 1;
    summarize;
  end
  initial begin
    repeat (4) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    s_gofs;
    s_adj;
    s_img;
    s_misc;
    summarize;
  end
endmodule
bind tuoh_handler tuoh_checker u_chk (
  .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .wr_in(wr_in), .rd_in(rd_in),
  .wdata_in(wdata_in), .busy_out(busy_out), .loop_rst_out(loop_rst_out),
  .save_cal_out(save_cal_out), .load_out(load_out), .load_def_out(load_def_out),
  .coarse_out(coarse_out), .fine_out(fine_out));
